// ===== rtl/sdp_serial_port.sv
/*
 * Serial device port: control register bit-banging of clock, data and
 * select pins, plus a queued fast write that shifts 1 to 5 bits out.
 * Assumes pins sensed asynchronously and a single-cycle register port.
 */

// small synchronous FIFO with valid/ready on both sides
module sdp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // clock and control
    input  wire logic             clk_sys,
    input  wire logic             sys_rst,
    input  wire logic             clkEn,
    // fill side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // drain side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PW:0]   FULL_CNT = (PW + 1)'(DEPTH);
    localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

    // occupancy is one bit wider than the pointers, so a full queue and
    // an empty one never look alike
    typedef struct packed {
        logic [PW-1:0] wrPtr;
        logic [PW-1:0] rdPtr;
        logic [PW:0]   used;
    } sdp_fifo_st_t;

    sdp_fifo_st_t     st;
    sdp_fifo_st_t     next_st;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             doWr;
    logic             doRd;

    // handshakes from occupancy
    assign inReady  = (st.used != FULL_CNT);
    assign outValid = (st.used != '0);
    // head word shown combinationally; it only means something while
    // outValid is high
    assign outData  = mem[st.rdPtr];
    assign doWr     = inValid && inReady;
    assign doRd     = outValid && outReady;

    // pointer and occupancy update
    always_comb begin
        next_st = st;
        if (doWr) begin
            next_st.wrPtr = (st.wrPtr == LAST_PTR) ? '0 : st.wrPtr + 1'b1;
        end
        if (doRd) begin
            next_st.rdPtr = (st.rdPtr == LAST_PTR) ? '0 : st.rdPtr + 1'b1;
        end
        case ({doWr, doRd})
            2'b10:   next_st.used = st.used + 1'b1;
            2'b01:   next_st.used = st.used - 1'b1;
            default: next_st.used = st.used;
        endcase
    end

    // state register
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            st <= '0;
        end else if (clkEn) begin
            st <= next_st;
        end
    end

    // storage array, written only on an accepted word
    always_ff @(posedge clk_sys) begin
        if (clkEn && doWr) begin
            mem[st.wrPtr] <= inData;
        end
    end

endmodule : sdp_fifo

// serial device port top
module sdp_serial_port
    import sdp_pkg::*;
#(
    parameter int DEPTH = sdp_pkg::FIFO_DEPTH
) (
    // clock, reset, enable
    input  wire logic                        clk_sys,
    input  wire logic                        sys_rst,
    input  wire logic                        clkEn,
    // register port
    input  wire logic [sdp_pkg::ADDR_W-1:0]  regAddr,
    input  wire logic [sdp_pkg::DATA_W-1:0]  regWdata,
    input  wire logic                        regWr,
    input  wire logic                        regRd,
    output logic      [sdp_pkg::DATA_W-1:0]  regRdata,
    // fast write queue has room
    output logic                             fastReady,
    // serial pins
    input  wire sdp_pkg::sdp_pin_in_t        pinIn,
    output sdp_pkg::sdp_pin_out_t            pinOut
);
    import sdp_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SETUP,
        ST_PULSE
    } sdp_eng_t;

    typedef struct packed {
        // control, fast write and config register image
        logic         dataBit;
        logic         triBit;
        logic         clkBit;
        logic         pulseBit;
        logic [2:0]   selBits;
        logic         divSel;
        logic         dropped;
        logic [DATA_W-1:0] fastLast;
        // fast transfer engine
        sdp_eng_t     eng;
        logic [4:0]   shift;
        logic [2:0]   left;
        logic         divTog;
        // one-cycle marker of a control register write
        logic         wrPulse;
        // pin synchroniser, read answer and pin drive
        sdp_pin_in_t  sync1;
        sdp_pin_in_t  sync2;
        logic [DATA_W-1:0] rdata;
        sdp_pin_out_t pins;
    } sdp_state_t;

    sdp_state_t st;
    sdp_state_t next_st;

    // queue signals
    logic       fastWr;
    logic       popReady;
    logic       popValid;
    sdp_fast_t  pushWord;
    sdp_fast_t  popWord;
    logic [2:0] capCount;
    logic       tick;

    // a fast write that finds the queue full is lost; the drop flag says so
    // every fast offset write offered to the queue
    assign fastWr   = regWr && (regAddr == OFS_FAST);
    assign pushWord = '{count: regWdata[FST_CNT_HI:FST_CNT_LO],
                        data:  regWdata[FST_DATA_HI:0]};
    // pop only while idle, so no word lands in the middle of a transfer
    assign popReady = (st.eng == ST_IDLE);

    assign capCount = (popWord.count > MAX_BITS) ? MAX_BITS : popWord.count;

    // divTog restarts at zero for each word, so setup and pulse each last
    // exactly two cycles in the divided mode
    // tick each cycle or every second cycle
    assign tick = st.divSel ? st.divTog : 1'b1;

    sdp_fifo #(
        .WIDTH ($bits(sdp_fast_t)),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk_sys  (clk_sys),
        .sys_rst  (sys_rst),
        .clkEn    (clkEn),
        .inValid  (fastWr),
        .inReady  (fastReady),
        .inData   (pushWord),
        .outValid (popValid),
        .outReady (popReady),
        .outData  (popWord)
    );

    // next-state logic for registers, engine, sync and pins
    always_comb begin
        next_st = st;
        // two-flop synchroniser on the sensed pins
        next_st.sync1   = pinIn;
        next_st.sync2   = st.sync1;
        next_st.wrPulse = 1'b0;

        // register writes
        if (regWr) begin
            case (regAddr)
                OFS_CTRL: begin
                    next_st.dataBit  = regWdata[CTL_DATA];
                    next_st.triBit   = regWdata[CTL_TRI];
                    next_st.clkBit   = regWdata[CTL_CLK];
                    next_st.pulseBit = regWdata[CTL_PULSE];
                    next_st.selBits  = regWdata[CTL_SEL_HI:CTL_SEL_LO];
                    next_st.wrPulse  = 1'b1;
                end
                OFS_FAST: begin
                    next_st.fastLast = regWdata;
                    if (!fastReady) begin
                        next_st.dropped = 1'b1; // queue full
                    end
                end
                OFS_CFG: begin
                    next_st.divSel = regWdata[CFG_DIV];
                    if (regWdata[CFG_DROP]) begin
                        next_st.dropped = 1'b0; // write one clears
                    end
                end
                default: begin
                end
            endcase
        end
        // lost word sets again over a clear in the same cycle
        if (fastWr && !fastReady) begin
            next_st.dropped = 1'b1;
        end

        // register reads, answer in the following cycle
        // cycles without a read return zero on the read data
        next_st.rdata = '0;
        if (regRd) begin
            case (regAddr)
                OFS_CTRL: begin
                    next_st.rdata[CTL_DATA] = st.sync2.sdata;
                    next_st.rdata[CTL_TRI]  = st.triBit;
                    next_st.rdata[CTL_CLK]  = st.sync2.sclk;
                    next_st.rdata[CTL_PULSE] = st.pulseBit;
                    next_st.rdata[CTL_SEL_HI:CTL_SEL_LO] = st.sync2.sel;
                end
                OFS_FAST: next_st.rdata = st.fastLast;
                OFS_CFG: begin
                    next_st.rdata[CFG_DIV]  = st.divSel;
                    next_st.rdata[CFG_BUSY] = (st.eng != ST_IDLE);
                    next_st.rdata[CFG_PEND] = popValid;
                    next_st.rdata[CFG_DROP] = st.dropped;
                end
                default: next_st.rdata = '0;
            endcase
        end

        // fast transfer engine
        next_st.divTog = (st.eng == ST_IDLE) ? 1'b0 : ~st.divTog;
        case (st.eng)
            ST_IDLE: begin
                if (popValid) begin
                    next_st.shift = popWord.data;
                    next_st.left  = capCount;
                    if (capCount != '0) begin
                        next_st.eng = ST_SETUP;
                    end
                end
            end
            ST_SETUP: begin
                if (tick) begin
                    next_st.eng = ST_PULSE;
                end
            end
            ST_PULSE: begin
                if (tick) begin
                    next_st.shift = {1'b0, st.shift[4:1]};
                    next_st.left  = st.left - 1'b1;
                    // last bit goes straight back to idle, data to stored bit
                    next_st.eng   = (st.left == 3'h1) ? ST_IDLE : ST_SETUP;
                end
            end
            default: next_st.eng = ST_IDLE;
        endcase

        // pin drive, registered from the next state
        // select pins inverted
        next_st.pins.sel     = ~next_st.selBits;
        // the enable follows the tristate bit in a fast transfer too; a set
        // bit keeps the fast bits off the pin
        // tristate control
        next_st.pins.sdataOe = ~next_st.triBit;
        if (next_st.eng == ST_IDLE) begin
            next_st.pins.sdata = next_st.dataBit;
            // inverted idle level during the strobe
            next_st.pins.sclk  = next_st.clkBit ^
                                 (next_st.pulseBit & next_st.wrPulse);
        end else begin
            next_st.pins.sdata = next_st.shift[0] ^ next_st.dataBit;
            next_st.pins.sclk  = next_st.clkBit ^
                                 (next_st.eng == ST_PULSE);
        end
    end

    // state register with reset and clock enable
    // clkEn low holds every bit here; the queue has its own gate
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            st              <= '0;
            st.eng          <= ST_IDLE;
            st.selBits      <= SEL_RESET;
            st.fastLast     <= FAST_RESET;
            st.pins.sel     <= ~SEL_RESET;
            st.pins.sdataOe <= 1'b1;
            // synchroniser starts at the select levels driven in reset, so
            // a read right after reset already returns them
            st.sync1.sel    <= ~SEL_RESET;
            st.sync2.sel    <= ~SEL_RESET;
        end else if (clkEn) begin
            st <= next_st;
        end
    end

    // outputs straight from flops
    assign regRdata = st.rdata;
    assign pinOut   = st.pins;

endmodule : sdp_serial_port

// ===== rtl/sdp_pkg.sv
/*
 * Shared constants and carrier types of the serial device port: register
 * offsets, bit positions, reset values and the pin bundles.
 * Assumes a single system clock and an 8-bit register port.
 */
package sdp_pkg;

    // register port geometry
    localparam int             ADDR_W        = 4;
    localparam int             DATA_W        = 8;
    localparam logic [ADDR_W-1:0] OFS_CTRL   = 4'h0; // serial_device_control
    localparam logic [ADDR_W-1:0] OFS_FAST   = 4'h1; // fast_serial_write
    localparam logic [ADDR_W-1:0] OFS_CFG    = 4'h2; // misc_config_register

    // serial_device_control bit positions
    localparam int             CTL_DATA      = 0;
    localparam int             CTL_TRI       = 1;
    localparam int             CTL_CLK       = 2;
    localparam int             CTL_PULSE     = 3;
    localparam int             CTL_SEL_LO    = 4;
    localparam int             CTL_SEL_HI    = 6;

    // fast_serial_write field positions
    localparam int             FST_DATA_HI   = 4;
    localparam int             FST_CNT_LO    = 5;
    localparam int             FST_CNT_HI    = 7;

    // misc_config_register bit positions
    localparam int             CFG_DIV       = 0;
    localparam int             CFG_BUSY      = 1;
    localparam int             CFG_PEND      = 2;
    localparam int             CFG_DROP      = 3;

    // reset values and limits
    localparam logic [2:0]     SEL_RESET     = 3'h0;
    localparam logic [2:0]     MAX_BITS      = 3'h5;
    localparam logic [DATA_W-1:0] FAST_RESET = 8'h00;
    localparam int             FIFO_DEPTH    = 8;

    // fast transfer word as queued
    typedef struct packed {
        logic [2:0] count;
        logic [4:0] data;
    } sdp_fast_t;

    // pin levels driven out
    typedef struct packed {
        logic       sclk;
        logic       sdata;
        logic       sdataOe;
        logic [2:0] sel;
    } sdp_pin_out_t;

    // pin levels sensed back
    typedef struct packed {
        logic       sclk;
        logic       sdata;
        logic [2:0] sel;
    } sdp_pin_in_t;

endpackage : sdp_pkg

// ===== dv/sdp_port_sva.sv
/*
 * Pin and register read checks of the serial device port.
 * Assumes clkEn stays high while the port is exercised.
 */
module sdp_port_sva
    import sdp_pkg::*;
(
    // clock and reset
    input wire logic                       clk_sys,
    input wire logic                       sys_rst,
    input wire logic                       clkEn,
    // register port
    input wire logic [sdp_pkg::ADDR_W-1:0] regAddr,
    input wire logic [sdp_pkg::DATA_W-1:0] regWdata,
    input wire logic                       regWr,
    input wire logic                       regRd,
    input wire logic [sdp_pkg::DATA_W-1:0] regRdata,
    // pins
    input wire sdp_pkg::sdp_pin_in_t       pinIn,
    input wire sdp_pkg::sdp_pin_out_t      pinOut
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] quiet;
    logic       ctlWr;
    logic       idle;
    logic       fastExp;
    logic       fastIdle;
    assign ctlWr = regWr && clkEn && regAddr == OFS_CTRL;
    assign idle  = quiet == 8'hFF;
    // cycles since the last fast write, and what its first bit should be
    always_ff @(posedge clk_sys) begin
        if (regWr && clkEn && regAddr == OFS_FAST) begin
            fastExp  <= regWdata[0] ^ pinOut.sdata;
            fastIdle <= pinOut.sclk;
        end
        if (sys_rst) quiet <= 8'hFF;
        else if (regWr && clkEn && regAddr == OFS_FAST) quiet <= 8'h00;
        else if (!idle) quiet <= quiet + 8'h01;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    a_tri_release: assert property (ctlWr
        |=> pinOut.sdataOe == !$past(regWdata[CTL_TRI]))
        else $error("data pin enable wrong");
    a_data_drive: assert property (ctlWr && idle
        |=> pinOut.sdata == $past(regWdata[CTL_DATA]))
        else $error("data pin level wrong");
    a_sel_invert: assert property (ctlWr
        |=> pinOut.sel == ~$past(regWdata[CTL_SEL_HI:CTL_SEL_LO]))
        else $error("select pins not inverted");
    a_pulse_once: assert property (ctlWr && idle && regWdata[CTL_PULSE]
        |=> pinOut.sclk != $past(regWdata[CTL_CLK])
        ##1 pinOut.sclk == $past(regWdata[CTL_CLK], 2))
        else $error("auto pulse wrong");
    a_clk_level: assert property (ctlWr && idle && !regWdata[CTL_PULSE]
        |=> pinOut.sclk == $past(regWdata[CTL_CLK]) ##1 $stable(pinOut.sclk))
        else $error("clock pin level wrong");
    a_fast_quiet: assert property (regRd && regAddr == OFS_FAST && idle
        |=> $stable(pinOut)[*2])
        else $error("pins moved on fast read");
    a_clk_readback: assert property (regRd && regAddr == OFS_CTRL
        && $stable(pinIn.sclk) && pinIn.sclk == $past(pinIn.sclk, 2)
        |=> regRdata[CTL_CLK] == $past(pinIn.sclk)) else $error("clock read");
    a_data_readback: assert property (regRd && regAddr == OFS_CTRL
        && $stable(pinIn.sdata) && pinIn.sdata == $past(pinIn.sdata, 2)
        |=> regRdata[CTL_DATA] == $past(pinIn.sdata)) else $error("data read");
    a_fast_start: assert property (regWr && regAddr == OFS_FAST
        && idle && regWdata[7:5] != 3'h0 |-> ##[2:3] (pinOut.sdata == fastExp
        && pinOut.sclk == fastIdle) ##1 pinOut.sclk != fastIdle)
        else $error("fast transfer start wrong");
endmodule : sdp_port_sva

// ===== dv/sdp_dev_model.sv
/*
 * Far-side serial device: loops pins back with a pull-up on data and
 * counts each bit where the clock leaves its idle level, recording the first five.
 */
module sdp_dev_model
    import sdp_pkg::*;
(
    // clock and bench control
    input  wire logic                  clk_sys,
    input  wire logic                  idleLevel,
    input  wire logic                  clear,
    // pins
    input  wire sdp_pkg::sdp_pin_out_t pinOut,
    output sdp_pkg::sdp_pin_in_t       pinIn,
    // captured traffic
    output logic [4:0]                 rxBits,
    output logic [7:0]                 rxCount,
    output logic [3:0]                 pulseLen
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       prevClk;
    logic [3:0] run;
    // released data line floats up to the pull-up level
    assign pinIn = {pinOut.sclk, pinOut.sdataOe ? pinOut.sdata : 1'b1,
                    pinOut.sel};
    // capture data on the leading clock edge, measure pulse length
    always @(posedge clk_sys) begin
        prevClk <= pinOut.sclk;
        if (clear) begin
            rxCount  <= 8'h00;
            rxBits   <= 5'h00;
            run      <= 4'h0;
            pulseLen <= 4'h0;
        end else begin
            if (pinOut.sclk != idleLevel && prevClk == idleLevel) begin
                if (rxCount < 8'h05) rxBits[rxCount[2:0]] <= pinOut.sdata;
                rxCount <= rxCount + 8'h01;
            end
            run <= (pinOut.sclk != idleLevel) ? run + 4'h1 : 4'h0;
            if (pinOut.sclk == idleLevel && run != 4'h0) pulseLen <= run;
        end
    end
endmodule : sdp_dev_model

// ===== dv/tb.sv
/*
 * Bench of the serial device port: register tasks, scenario tasks and
 * a device model on the pins. Assumes sdp_pkg is compiled first.
 */
module tb
    import sdp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] FW [6] = '{8'h3B, 8'hB6, 8'h65, 8'hF3, 8'h1F,
                                      8'hD5};
    logic              clk_sys = 1'b0;
    logic              sys_rst = 1'b1;
    logic              clkEn = 1'b1;
    logic              regWr = 1'b0;
    logic              regRd = 1'b0;
    logic [ADDR_W-1:0] regAddr = '0;
    logic [DATA_W-1:0] regWdata = '0;
    logic [DATA_W-1:0] regRdata;
    logic              fastReady;
    logic              idleLevel = 1'b0;
    logic              clear = 1'b0;
    sdp_pin_in_t       pinIn;
    sdp_pin_out_t      pinOut;
    logic [4:0]        rxBits;
    logic [7:0]        rxCount;
    logic [3:0]        pulseLen;
    int                n_fail = 0;
    int                n_checks = 0;
    int                cyc = 0;
    sdp_serial_port #(.DEPTH(FIFO_DEPTH)) u_dut (.clk_sys, .sys_rst, .clkEn,
        .regAddr, .regWdata, .regWr, .regRd, .regRdata, .fastReady, .pinIn,
        .pinOut);
    sdp_dev_model u_dev (.clk_sys, .idleLevel, .clear, .pinOut, .pinIn,
        .rxBits, .rxCount, .pulseLen);
    // clock and hang guard
    always #50 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            finish_test();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'b1;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1 chk(regRdata, exp);
    endtask : rd
    task automatic clr();
        clear <= 1'b1;
        @(posedge clk_sys);
        clear <= 1'b0;
    endtask : clr
    task automatic t_reset();
        rd(OFS_CTRL, 8'h70);
        rd(OFS_FAST, FAST_RESET);
        rd(OFS_CFG, 8'h00);
        rd(4'hF, 8'h00);
    endtask : t_reset
    task automatic t_bitbang();
        wr(OFS_CTRL, 8'h15);
        // pin readback passes two sync flops: one spare edge before the read
        @(posedge clk_sys);
        rd(OFS_CTRL, 8'h65);
        chk(pinOut.sel, 8'h6);
        wr(OFS_CTRL, 8'h06);
        #1 chk(pinOut.sdataOe, 8'h0);
        @(posedge clk_sys);
        rd(OFS_CTRL, 8'h77);
        wr(OFS_CTRL, 8'h00);
    endtask : t_bitbang
    task automatic t_pulse();
        for (int i = 0; i < 2; i++) begin
            wr(OFS_CTRL, 8'(i << 2));
            idleLevel <= i[0];
            clr();
            wr(OFS_CTRL, 8'(8 | i << 2));
            repeat (3) @(posedge clk_sys);
            chk(pulseLen, 8'h1);
            chk(rxCount, 8'h1);
            // auto pulse off before idle level changes
            wr(OFS_CTRL, 8'(i << 2));
        end
    endtask : t_pulse
    task automatic t_fast();
        logic [2:0] n;
        logic [4:0] m;
        for (int v = 0; v < 2; v++) for (int i = 0; i < 6; i++) begin
            n = (FW[i][7:5] > MAX_BITS) ? MAX_BITS : FW[i][7:5];
            m = 5'((1 << n) - 1);
            wr(OFS_CFG, 8'(v));
            wr(OFS_CTRL, {4'h7, 1'b0, i[1], 1'b0, i[0]});
            idleLevel <= i[1];
            clr();
            wr(OFS_FAST, FW[i]);
            repeat (260) @(posedge clk_sys);
            chk(rxCount, 8'(n));
            chk(rxBits & m, (FW[i][4:0] ^ {5{i[0]}}) & m);
            chk(pulseLen, (n == 0) ? 8'h0 : 8'(v + 1));
            chk({pinOut.sclk, pinOut.sdata}, 8'(i[1:0]));
            chk(pinOut.sel, 8'h0);
            rd(OFS_FAST, FW[i]);
            repeat (3) @(posedge clk_sys);
            chk(rxCount, 8'(n));
        end
    endtask : t_fast
    task automatic t_fifo();
        wr(OFS_CFG, 8'h01);
        wr(OFS_CTRL, 8'h70);
        idleLevel <= 1'b0;
        clr();
        for (int i = 0; i < 10; i++) begin
            if (i == 9) #1 chk(fastReady, 8'h0);
            wr(OFS_FAST, 8'hBF);
        end
        repeat (250) @(posedge clk_sys);
        chk(rxCount, 8'd45);
        chk(rxBits, 8'h1F);
        rd(OFS_CFG, 8'h09);
        wr(OFS_CFG, 8'h09);
        rd(OFS_CFG, 8'h01);
        chk(fastReady, 8'h1);
    endtask : t_fifo
    // a control write while clkEn is low must leave every pin alone
    task automatic t_hold();
        @(posedge clk_sys);
        clkEn <= 1'b0;
        wr(OFS_CTRL, 8'h07);
        clkEn <= 1'b1;
        #1 chk(pinOut.sdataOe, 8'h1);
        chk({pinOut.sclk, pinOut.sdata}, 8'h0);
        chk(pinOut.sel, 8'h0);
    endtask : t_hold
    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : finish_test
    // main sequence
    initial begin
        repeat (16) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_reset();
        t_bitbang();
        t_pulse();
        t_fast();
        t_fifo();
        t_hold();
        finish_test();
    end
endmodule : tb
bind sdp_serial_port sdp_port_sva u_sva (.clk_sys, .sys_rst, .clkEn,
    .regAddr, .regWdata, .regWr, .regRd, .regRdata, .pinIn, .pinOut);
